// *** hw/rhp_consts.vh ***
// Constants for the rotator host port controller.
`ifndef RHP_CONSTS_VH
`define RHP_CONSTS_VH

// ****************************************************************
// Control/status word field layout.
// ****************************************************************
`define RHP_EN_BIT      15
`define RHP_FC_BIT      14
`define RHP_CLP_BIT     13
`define RHP_RW_BIT      12
`define RHP_RT_HI       11
`define RHP_RT_LO       10
`define RHP_XS_HI       9
`define RHP_XS_LO       8
`define RHP_YS_HI       7
`define RHP_YS_LO       2
`define RHP_RSVD_MASK   16'hfffc
`define RHP_CSR_RESET   16'h0000

// ****************************************************************
// Command codes on the user port.
// ****************************************************************
`define RHP_OP_CSR_WR   3'h0
`define RHP_OP_CSR_RD   3'h1
`define RHP_OP_ARR_WR   3'h2
`define RHP_OP_ARR_RD   3'h3
`define RHP_OP_FB_WR    3'h4
`define RHP_OP_FB_RD    3'h5
`define RHP_OP_RESET    3'h6

// ****************************************************************
// Bus timing, in ns, and the clock period.
// ****************************************************************
`define RHP_CLK_NS      10
`define RHP_SETUP_NS    20
`define RHP_STROBE_NS   50
`define RHP_HOLD_NS     20
`define RHP_RESET_NS    200
`define RHP_CYC(ns)     (((ns) + `RHP_CLK_NS - 1) / `RHP_CLK_NS)

`endif

// *** hw/rhp_fifo.v ***
// Small FIFO with a registered output stage.
`timescale 1ns/10ps
module rhp_fifo #(
  parameter W  = 16,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output reg          out_valid_q,
  input  wire         out_ready,
  output reg  [W-1:0] out_data_q
);
  localparam [31:0]   D_W  = D;
  localparam [31:0]   D_M1 = D - 1;
  localparam [AW:0]   FULL = D_W[AW:0];
  localparam [AW-1:0] LAST = D_M1[AW-1:0];

  reg  [W-1:0]  mem [0:D-1];
  reg  [AW-1:0] wp_q;
  reg  [AW-1:0] rp_q;
  reg  [AW:0]   cnt_q;
  wire          push;
  wire          load;

  // Handshakes on both sides of the store.
  assign in_ready = (cnt_q != FULL);
  assign push     = in_valid && in_ready;
  assign load     = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);

  // Storage array, written without reset.
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointers, level and the output register.
  always @(posedge clk) begin
    if (srst) begin
      wp_q        <= {AW{1'b0}};
      rp_q        <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q  <= {W{1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == LAST) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (load) begin
        rp_q        <= (rp_q == LAST) ? {AW{1'b0}} : rp_q + 1'b1;
        out_data_q  <= mem[rp_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push && !load) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (load && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// *** hw/rhp_host.v ***
// Host controller driving the rotator's parallel bus pins.
`timescale 1ns/10ps
`include "rhp_consts.vh"

module rhp_host #(
  parameter DW        = 16,
  parameter FIFO_D    = 8,
  parameter FIFO_AW   = 3,
  parameter UNREVERSE = 0
) (
  input  wire          clk,
  input  wire          srst,
  input  wire          cmd_valid,
  output reg           cmd_ready_q,
  input  wire [2:0]    cmd_op,
  input  wire [DW-1:0] cmd_data,
  output reg           cmd_done_q,
  output reg           cmd_err_q,
  output wire          rd_valid,
  input  wire          rd_ready,
  output wire [DW-1:0] rd_data,
  output reg  [DW-1:0] csr_shadow_q,
  output reg           dev_reset_n_q,
  output reg           reg_select_n_q,
  output reg           group_select_n_q,
  output reg           flyby_select_n_q,
  output reg           access_start_q,
  output reg           rd_n_q,
  output reg           wr_n_q,
  output reg  [DW-1:0] data_out_q,
  output reg           data_oe_q,
  input  wire [DW-1:0] data_in
);
  // ****************************************************************
  // States and phase lengths.
  // ****************************************************************
  localparam [4:0] ST_IDLE   = 5'h01;
  localparam [4:0] ST_SETUP  = 5'h02;
  localparam [4:0] ST_STROBE = 5'h04;
  localparam [4:0] ST_HOLD   = 5'h08;
  localparam [4:0] ST_RST    = 5'h10;
  // Phase lengths are worked out wide, then cut to the counter width.
  localparam [31:0] SETUP_LEN  = `RHP_CYC(`RHP_SETUP_NS);
  localparam [31:0] STROBE_LEN = `RHP_CYC(`RHP_STROBE_NS);
  localparam [31:0] HOLD_LEN   = `RHP_CYC(`RHP_HOLD_NS);
  localparam [31:0] RESET_LEN  = `RHP_CYC(`RHP_RESET_NS);
  localparam [7:0]  SETUP_C    = SETUP_LEN[7:0];
  localparam [7:0]  STROBE_C   = STROBE_LEN[7:0];
  localparam [7:0]  HOLD_C     = HOLD_LEN[7:0];
  localparam [7:0]  RESET_C    = RESET_LEN[7:0];

  reg  [4:0]    state_q;
  reg  [7:0]    cnt_q;
  reg  [2:0]    op_q;
  reg  [DW-1:0] din_s1_q;
  reg  [DW-1:0] din_s2_q;
  reg  [DW-1:0] word_q;
  reg           push_q;
  wire          fifo_in_ready;
  wire          accept;
  wire          is_arr;
  wire          want_rd;
  wire          gate_ok;
  wire          dir_ok;
  wire          rev_mode;
  wire [DW-1:0] din_rev;

  // Bit order reversal of a word.
  function [DW-1:0] rhp_rev;
    input [DW-1:0] w;
    integer i;
    begin
      for (i = 0; i < DW; i = i + 1) begin
        rhp_rev[i] = w[DW-1-i];
      end
    end
  endfunction

  // ****************************************************************
  // Command decode and host-side legality checks.
  // ****************************************************************
  assign accept  = cmd_valid && cmd_ready_q;
  assign is_arr  = (cmd_op == `RHP_OP_ARR_WR) || (cmd_op == `RHP_OP_ARR_RD) ||
                   (cmd_op == `RHP_OP_FB_WR) || (cmd_op == `RHP_OP_FB_RD);
  assign want_rd = (cmd_op == `RHP_OP_ARR_RD) || (cmd_op == `RHP_OP_FB_RD);
  // The device ignores array work unless both enable and token are set.
  assign gate_ok = csr_shadow_q[`RHP_EN_BIT] &&
                   csr_shadow_q[`RHP_FC_BIT];
  // Direction selects read-only or write-only array access.
  assign dir_ok  = (csr_shadow_q[`RHP_RW_BIT] == want_rd);
  // Rotations 180 and 270 come back bit-reversed.
  assign rev_mode = csr_shadow_q[`RHP_RT_HI];
  assign din_rev  = (UNREVERSE != 0 && rev_mode) ?
                    rhp_rev(din_s2_q) : din_s2_q;

  // Two-flop synchroniser for the bus as seen from the pins.
  always @(posedge clk) begin
    if (srst) begin
      din_s1_q <= {DW{1'b0}};
      din_s2_q <= {DW{1'b0}};
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // ****************************************************************
  // Bus sequencer.
  // ****************************************************************
  // Each access is setup, strobe low, then hold with start still high.
  always @(posedge clk) begin
    if (srst) begin
      state_q          <= ST_RST;
      cnt_q            <= 8'h00;
      op_q             <= `RHP_OP_RESET;
      cmd_ready_q      <= 1'b0;
      cmd_done_q       <= 1'b0;
      cmd_err_q        <= 1'b0;
      csr_shadow_q     <= `RHP_CSR_RESET;
      dev_reset_n_q    <= 1'b0;
      reg_select_n_q   <= 1'b1;
      group_select_n_q <= 1'b1;
      flyby_select_n_q <= 1'b1;
      access_start_q   <= 1'b0;
      rd_n_q           <= 1'b1;
      wr_n_q           <= 1'b1;
      data_out_q       <= {DW{1'b0}};
      data_oe_q        <= 1'b0;
      word_q           <= {DW{1'b0}};
      push_q           <= 1'b0;
    end else begin
      cmd_done_q <= 1'b0;
      cmd_err_q  <= 1'b0;
      push_q     <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // A word still entering the buffer may fill it, so wait a cycle.
          cmd_ready_q <= fifo_in_ready && !push_q && !accept;
          if (accept) begin
            op_q  <= cmd_op;
            cnt_q <= 8'h00;
            if (cmd_op == `RHP_OP_RESET) begin
              state_q       <= ST_RST;
              dev_reset_n_q <= 1'b0;
            end else if (cmd_op > `RHP_OP_RESET ||
                         (is_arr && !(gate_ok && dir_ok))) begin
              cmd_err_q <= 1'b1;
              cmd_done_q <= 1'b1;
            end else begin
              state_q        <= ST_SETUP;
              access_start_q <= 1'b1;
              reg_select_n_q <= !((cmd_op == `RHP_OP_CSR_WR) ||
                                  (cmd_op == `RHP_OP_CSR_RD));
              group_select_n_q <= !((cmd_op == `RHP_OP_ARR_WR) ||
                                    (cmd_op == `RHP_OP_ARR_RD));
              flyby_select_n_q <= !((cmd_op == `RHP_OP_FB_WR) ||
                                    (cmd_op == `RHP_OP_FB_RD));
              // Reserved bits are forced to zero on register writes.
              data_out_q <= (cmd_op == `RHP_OP_CSR_WR) ?
                            (cmd_data & `RHP_RSVD_MASK) : cmd_data;
              // Host drives the bus only for its own writes.
              data_oe_q  <= (cmd_op == `RHP_OP_CSR_WR) ||
                            (cmd_op == `RHP_OP_ARR_WR);
            end
          end
        end
        ST_SETUP: begin
          if (cnt_q == SETUP_C - 8'h01) begin
            cnt_q   <= 8'h00;
            state_q <= ST_STROBE;
            // Fly-by swaps the strobes: read stores, write fetches.
            rd_n_q  <= !((op_q == `RHP_OP_CSR_RD) || (op_q == `RHP_OP_ARR_RD) ||
                         (op_q == `RHP_OP_FB_WR));
            wr_n_q  <= !((op_q == `RHP_OP_CSR_WR) || (op_q == `RHP_OP_ARR_WR) ||
                         (op_q == `RHP_OP_FB_RD));
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_STROBE: begin
          if (cnt_q == STROBE_C - 8'h01) begin
            cnt_q   <= 8'h00;
            state_q <= ST_HOLD;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            // Sample just before the strobe rises while the device drives.
            word_q  <= (op_q == `RHP_OP_ARR_RD) ? din_rev : din_s2_q;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_HOLD: begin
          if (cnt_q == HOLD_C - 8'h01) begin
            cnt_q            <= 8'h00;
            state_q          <= ST_IDLE;
            access_start_q   <= 1'b0;
            reg_select_n_q   <= 1'b1;
            group_select_n_q <= 1'b1;
            flyby_select_n_q <= 1'b1;
            data_oe_q        <= 1'b0;
            cmd_done_q       <= 1'b1;
            push_q <= (op_q == `RHP_OP_CSR_RD) || (op_q == `RHP_OP_ARR_RD);
            if (op_q == `RHP_OP_CSR_WR) begin
              csr_shadow_q <= data_out_q;
            end else if (op_q == `RHP_OP_CSR_RD) begin
              // Readback carries next Y and X size after clipping.
              csr_shadow_q <= word_q;
            end else begin
              // Any array access leaves the device in clipped state.
              csr_shadow_q[`RHP_CLP_BIT] <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_RST: begin
          // Device reset clears its register; bus stays released.
          data_oe_q <= 1'b0;
          if (cnt_q == RESET_C - 8'h01) begin
            cnt_q         <= 8'h00;
            state_q       <= ST_IDLE;
            dev_reset_n_q <= 1'b1;
            csr_shadow_q  <= `RHP_CSR_RESET;
            cmd_done_q    <= (op_q == `RHP_OP_RESET);
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read data buffer toward the user.
  // ****************************************************************
  rhp_fifo #(
    .W  (DW),
    .D  (FIFO_D),
    .AW (FIFO_AW)
  ) u_fifo (
    .clk         (clk),
    .srst        (srst),
    .in_valid    (push_q),
    .in_ready    (fifo_in_ready),
    .in_data     (word_q),
    .out_valid_q (rd_valid),
    .out_ready   (rd_ready),
    .out_data_q  (rd_data)
  );
endmodule

// *** dv/rhp_host_assertions.sv ***
// Checker of the host controller's pins and command port.
`timescale 1ns/10ps
module rhp_host_assertions #(
  parameter DW = 16
) (
  input          clk,
  input          srst,
  input          cmd_valid,
  input          cmd_ready_q,
  input [2:0]    cmd_op,
  input          cmd_done_q,
  input          cmd_err_q,
  input [DW-1:0] csr_shadow_q,
  input          dev_reset_n_q,
  input          reg_select_n_q,
  input          flyby_select_n_q,
  input          access_start_q,
  input          rd_n_q,
  input          wr_n_q,
  input [DW-1:0] data_out_q,
  input          data_oe_q
);
  // ****************
  // Properties.
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // An array command taken by the controller.
  wire arr = cmd_valid && cmd_ready_q && cmd_op >= 3'h2 && cmd_op <= 3'h5;
  property p_start; (!rd_n_q || !wr_n_q) |-> access_start_q; endproperty
  a_start: assert property (p_start) else $error("strobe no start");
  property p_oe; data_oe_q |-> rd_n_q && flyby_select_n_q; endproperty
  a_oe: assert property (p_oe) else $error("host drives on read");
  property p_wdat;
    (!wr_n_q && flyby_select_n_q) |-> data_oe_q && $stable(data_out_q);
  endproperty
  a_wdat: assert property (p_wdat) else $error("write data moved");
  property p_rlen; $fell(rd_n_q) |-> !rd_n_q [*5] ##1 rd_n_q; endproperty
  a_rlen: assert property (p_rlen) else $error("read strobe length");
  property p_ref;
    arr && !(csr_shadow_q[15] && csr_shadow_q[14]) |=> cmd_err_q && cmd_done_q;
  endproperty
  a_ref: assert property (p_ref) else $error("not refused");
  property p_rw; arr && cmd_op[0] != csr_shadow_q[12] |=> cmd_err_q; endproperty
  a_rw: assert property (p_rw) else $error("direction not refused");
  property p_rsv;
    (!wr_n_q && !reg_select_n_q) |-> data_out_q[1:0] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_drst;
    (cmd_valid && cmd_ready_q && cmd_op == 3'h6) |=> !dev_reset_n_q [*8];
  endproperty
  a_drst: assert property (p_drst) else $error("device reset short");
  c_err: cover property (cmd_err_q);
  c_rd: cover property (!rd_n_q && !reg_select_n_q);
  c_fly: cover property (!flyby_select_n_q && !wr_n_q);
endmodule
bind rhp_host rhp_host_assertions #(.DW(DW)) rhp_host_assertions_i (
  .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q),
  .cmd_op(cmd_op), .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
  .csr_shadow_q(csr_shadow_q), .dev_reset_n_q(dev_reset_n_q),
  .reg_select_n_q(reg_select_n_q), .flyby_select_n_q(flyby_select_n_q),
  .access_start_q(access_start_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q),
  .data_out_q(data_out_q), .data_oe_q(data_oe_q));

// *** dv/rhp_dev_model.sv ***
// Behavioural model of the rotation device on the host bus.
`timescale 1ns/10ps
module rhp_dev_model (
  input             reset_n,
  input             cs_n,
  input             gs_n,
  input             fb_n,
  input             st,
  input             rd_n,
  input             wr_n,
  input      [15:0] bus,
  output reg [15:0] csr_q,
  output     [15:0] drv,
  output            drv_oe,
  input             right_token_in,
  input             down_bypass_line,
  output            up_270_token_out
);
  // ****************
  // Register, array and bus drive.
  // ****************
  reg  [15:0] mem [0:15];
  reg  [3:0]  wp_q;
  reg  [3:0]  rp_q;
  reg         wl_q;
  reg  [15:0] rv;
  wire        go = csr_q[15] && csr_q[14];
  wire        rdop = wl_q == !fb_n;
  // Reads drive the bus only while their strobe is low.
  assign drv_oe = reset_n && st && (!cs_n && !rd_n || go && csr_q[12] &&
                  (!gs_n && !rd_n || !fb_n && !wr_n));
  assign drv = !cs_n ? csr_q : csr_q[11] ? rv : mem[rp_q];
  // Up-270 token: bypass of a disabled device in 270 read, or hand-off
  // once a 180 read has used up its section, taken here as one row.
  assign up_270_token_out = !(reset_n && csr_q[12] &&
    (!csr_q[15] && csr_q[11:10] == 2'h3 && !down_bypass_line ||
     csr_q[11:10] == 2'h2 && !right_token_in &&
     rp_q > {2'h0, csr_q[9:8]}));
  // Bit-reversed word for the 180 and 270 rotations.
  always @* for (int i = 0; i < 16; i++) rv[i] = mem[rp_q][15-i];
  // Remembers which strobe opened the access.
  always @(negedge rd_n or negedge wr_n) wl_q = !wr_n;
  // Writes land and the read pointer steps on a strobe's rising edge.
  always @(posedge rd_n or posedge wr_n or negedge reset_n) begin
    if (!reset_n) begin
      csr_q <= 16'h0000;
      wp_q <= 4'h0;
      rp_q <= 4'h0;
    end else if (st && !cs_n && wl_q) begin
      csr_q <= bus;
      wp_q <= 4'h0;
      rp_q <= 4'h0;
    end else if (st && go && (!gs_n || !fb_n) && csr_q[12] == rdop) begin
      csr_q[13] <= 1'b1;
      if (rdop) begin
        rp_q <= rp_q + 4'h1;
      end else begin
        mem[wp_q] <= bus;
        wp_q <= wp_q + 4'h1;
      end
    end
  end
endmodule

// *** dv/rhp_host_tb_top.sv ***
// Self-checking bench of the host controller against a device model.
`timescale 1ns/10ps
module rhp_host_tb_top;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg         cmd_valid = 1'b0;
  reg  [2:0]  cmd_op = 3'h0;
  reg  [15:0] cmd_data = 16'h0000;
  reg         rd_ready = 1'b0;
  reg  [15:0] fm_q = 16'h0000;
  reg  [15:0] flt_q = 16'h0000;
  reg  [15:0] fb_seen = 16'h0000;
  reg         rti_q = 1'b1;
  reg         dbl_q = 1'b1;
  reg  [15:0] w [0:7];
  reg  [15:0] c;
  int         fail_count = 0;
  int         check_count = 0;
  wire        cmd_ready_q, cmd_done_q, cmd_err_q, rd_valid, dev_reset_n_q;
  wire        cs_n, gs_n, fb_n, st, rd_n_q, wr_n_q, data_oe_q, dev_oe;
  wire [15:0] rd_data, csr_shadow_q, data_out_q, bus, drv, dev_csr;
  wire        u270_tok;
  // ****************
  // Design, device and bus.
  // ****************
  rhp_host rhp_host_i (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready_q(cmd_ready_q), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .csr_shadow_q(csr_shadow_q),
    .dev_reset_n_q(dev_reset_n_q), .reg_select_n_q(cs_n),
    .group_select_n_q(gs_n), .flyby_select_n_q(fb_n), .access_start_q(st),
    .rd_n_q(rd_n_q), .wr_n_q(wr_n_q), .data_out_q(data_out_q),
    .data_oe_q(data_oe_q), .data_in(bus));
  rhp_dev_model rhp_dev_model_i (.reset_n(dev_reset_n_q), .cs_n(cs_n),
    .gs_n(gs_n), .fb_n(fb_n), .st(st), .rd_n(rd_n_q), .wr_n(wr_n_q),
    .bus(bus), .csr_q(dev_csr), .drv(drv), .drv_oe(dev_oe),
    .right_token_in(rti_q), .down_bypass_line(dbl_q),
    .up_270_token_out(u270_tok));
  // Host, device, font memory in fly-by writes, else a drifting pattern.
  assign bus = data_oe_q ? data_out_q : dev_oe ? drv :
               (!fb_n && wr_n_q) ? fm_q : flt_q;
  initial forever #5 clk = ~clk;
  // Moves the idle pattern and catches fly-by read words.
  always @(negedge clk) begin
    flt_q <= flt_q + 16'h3b71;
    if (!fb_n && !wr_n_q) fb_seen <= bus;
  end
  function automatic [15:0] expw(input [15:0] v, input [1:0] rt);
    for (int i = 0; i < 16; i++) expw[i] = rt[1] ? v[15-i] : v[i];
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task hang(input int n);
    if (n >= 400) begin
      fail_count++;
      conclude;
    end
  endtask
  // Issues one command and checks whether it was refused.
  task automatic cmd(input [2:0] op, input [15:0] d, input e);
    int n = 0;
    cmd_op = op;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (cmd_ready_q !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (cmd_done_q !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    hang(n);
    chk({15'h0, cmd_err_q}, {15'h0, e});
  endtask
  task automatic pop(input [15:0] e);
    int n = 0;
    while (rd_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    hang(n);
    chk(rd_data, e);
    rd_ready = 1'b1;
    @(negedge clk);
    rd_ready = 1'b0;
    @(negedge clk);
  endtask
  // Main sequence.
  initial begin
    void'($urandom(72246));
    repeat (6) @(negedge clk);
    srst = 1'b0;
    chk(csr_shadow_q, 16'h0000);
    cmd(3'h6, 16'h0000, 1'b0);
    chk(dev_csr, 16'h0000);
    cmd(3'h2, 16'h1234, 1'b1);
    cmd(3'h7, 16'h0000, 1'b1);
    cmd(3'h0, 16'h8000, 1'b0);
    cmd(3'h2, 16'h0000, 1'b1);
    c = {4'hc, 12'($urandom) | 12'h003};
    cmd(3'h0, c, 1'b0);
    c[1:0] = 2'h0;
    chk(dev_csr, c);
    cmd(3'h1, 16'h0000, 1'b0);
    pop(c);
    cmd(3'h3, 16'h0000, 1'b1);
    for (int i = 0; i < 8; i++) begin
      w[i] = (i == 0) ? 16'h8001 : 16'($urandom);
      fm_q = w[i];
      cmd(i[0] ? 3'h4 : 3'h2, w[i], 1'b0);
    end
    chk(dev_csr, c | 16'h2000);
    chk(csr_shadow_q, c | 16'h2000);
    for (int r = 0; r < 4; r++) begin
      c = {4'hd, r[1:0], 10'($urandom) & 10'h3fc};
      rti_q = r[0];
      cmd(3'h0, c, 1'b0);
      cmd(3'h3, 16'h0000, 1'b0);
      pop(expw(w[0], r[1:0]));
      cmd(3'h5, 16'h0000, 1'b0);
      chk(fb_seen, expw(w[1], r[1:0]));
      chk({15'h0, u270_tok}, {15'h0, !(r == 2 && c[9:8] < 2'h2)});
    end
    cmd(3'h2, 16'h0000, 1'b1);
    rd_ready = 1'b1;
    repeat (3) @(negedge clk);
    rd_ready = 1'b0;
    for (int i = 0; i < 9; i++) cmd(3'h1, 16'h0000, 1'b0);
    repeat (20) @(negedge clk);
    chk({15'h0, cmd_ready_q}, 16'h0000);
    for (int i = 0; i < 9; i++) pop(c | 16'h2000);
    // Disabled device in 270 read passes the bypass to its up output.
    cmd(3'h0, 16'h1c00, 1'b0);
    dbl_q = 1'b0;
    @(negedge clk);
    chk({15'h0, u270_tok}, 16'h0000);
    dbl_q = 1'b1;
    @(negedge clk);
    chk({15'h0, u270_tok}, 16'h0001);
    conclude;
  end
endmodule
